/* File: src/mmx_pkg.sv */
// mmx_pkg: constants and types shared by the move and multiply execution datapath
// assumes a 12-bit data space split into 256-byte banks and a four-phase instruction cycle
package mmx_pkg;

  // opcode patterns, upper byte of the instruction word
  localparam logic [7:0] MMX_OP_LOAD_LIT = 8'h0E;
  localparam logic [7:0] MMX_OP_MUL_LIT = 8'h0D;
  localparam logic [6:0] MMX_OP_STORE_F = 7'h37;
  localparam logic [6:0] MMX_OP_MUL_F = 7'h01;

  // instruction word field positions
  localparam int MMX_OP_HI = 15;
  localparam int MMX_OP_LO = 8;
  localparam int MMX_ABIT_POS = 8;
  localparam int MMX_ARG_HI = 7;
  localparam int MMX_ARG_LO = 0;

  // access bank layout: low part in bank 0, high part in the top bank
  localparam logic [7:0] MMX_ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] MMX_INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] MMX_ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] MMX_ACCESS_HIGH_BANK = 4'hF;

  // values after reset
  localparam logic [7:0] MMX_ACC_RST = 8'h00;
  localparam logic [7:0] MMX_PROD_RST = 8'h00;

  // instruction cycle phases, one system clock each
  typedef enum logic [1:0] {
    MMX_PH_DECODE = 2'b00,
    MMX_PH_READ = 2'b01,
    MMX_PH_PROCESS = 2'b10,
    MMX_PH_WRITE = 2'b11
  } mmx_phase_t;

  // decoded operation
  typedef enum logic [2:0] {
    MMX_NONE = 3'b000,
    MMX_LOAD_LIT = 3'b001,
    MMX_STORE_F = 3'b010,
    MMX_MUL_LIT = 3'b011,
    MMX_MUL_F = 3'b100
  } mmx_op_t;

endpackage : mmx_pkg

/* File: src/mmx_addr_if.sv */
// mmx_addr_if: carries a file operand's addressing fields to the address former and the result back
// assumes both ends sit in the same clock domain; the path through it is purely combinational
`timescale 1ns/1ps
interface mmx_addr_if #(
  parameter int ADDR_W = 12,
  parameter int BANK_W = 4
);
  logic access_bit;
  logic [7:0] file_field;
  logic [BANK_W-1:0] bank_select_reg;
  logic ext_set_en;
  logic [ADDR_W-1:0] index_base;
  logic [ADDR_W-1:0] full_addr;
  logic indexed;

  modport former (
    input access_bit,
    input file_field,
    input bank_select_reg,
    input ext_set_en,
    input index_base,
    output full_addr,
    output indexed
  );

  modport user (
    output access_bit,
    output file_field,
    output bank_select_reg,
    output ext_set_en,
    output index_base,
    input full_addr,
    input indexed
  );
endinterface : mmx_addr_if

/* File: src/mmx_addr_gen.sv */
// mmx_addr_gen: forms the data-space address of a file operand
// assumes the caller registers the result; this leaf is combinational only
`timescale 1ns/1ps
module mmx_addr_gen
  import mmx_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int BANK_W = 4
) (
  mmx_addr_if.former addr
);

  // choose between banked, access bank and indexed literal offset forms
  always_comb begin
    addr.indexed = 1'b0;
    if (addr.access_bit) begin
      addr.full_addr = {addr.bank_select_reg, addr.file_field};
    end else if (addr.ext_set_en && (addr.file_field <= MMX_INDEX_LIMIT)) begin
      // indexed offset wraps inside the data space rather than faulting
      addr.indexed = 1'b1;
      addr.full_addr = addr.index_base + {{(ADDR_W-8){1'b0}}, addr.file_field};
    end else if (addr.file_field < MMX_ACCESS_SPLIT) begin
      addr.full_addr = {MMX_ACCESS_LOW_BANK, addr.file_field};
    end else begin
      addr.full_addr = {MMX_ACCESS_HIGH_BANK, addr.file_field};
    end
  end

endmodule : mmx_addr_gen

/* File: src/mmx_exec.sv */
// mmx_exec: execution datapath for literal load, accumulator store and the two unsigned multiplies
// assumes fetch hands over one instruction word in the decode phase and that data memory
// returns read data in the cycle after the read strobe
//
// Functional notes
// - the literal load writes its 8-bit literal into the accumulator and touches no flag.
// - the accumulator store copies the accumulator to the addressed file register without flag changes.
// - the 8-bit file field reaches every byte of the selected 256-byte bank.
// - bank-access bit 0 selects the access bank, 1 selects the bank named by the bank select value.
// - with the extended set on, bit clear and field at or below 95, indexed literal offset addressing is used.
// - the literal multiply forms the unsigned product of accumulator and literal.
// - the literal multiply puts the 16-bit product in the pair, high byte in the upper register.
// - the file multiply stores the unsigned accumulator times file register product in the pair.
// - neither multiply changes the accumulator, and the file multiply never writes the file register.
// - multiplies raise no flag, not zero, carry or overflow.
// - the file multiply is one word and one instruction cycle.
// - any literal from 0 to 255 is accepted by the load and the literal multiply.
`timescale 1ns/1ps
module mmx_exec
  import mmx_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int BANK_W = 4
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // instruction hand-over from fetch and decode
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  output logic INSTR_TAKE,
  // addressing context
  input wire logic [BANK_W-1:0] BANK_SEL,
  input wire logic EXT_SET_EN,
  input wire logic [ADDR_W-1:0] INDEX_BASE,
  // data memory port
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic MEM_RD,
  input wire logic [7:0] MEM_RDATA,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  // architectural state
  output logic [7:0] ACC,
  output logic [7:0] PROD_HI,
  output logic [7:0] PROD_LO,
  output logic DONE
);

  // the bank field plus the 8-bit file field must span the whole data space;
  // the access bank numbers are fixed in width, so the bank field must match them
  if (ADDR_W != BANK_W + 8 || BANK_W != $bits(MMX_ACCESS_HIGH_BANK)) begin : g_width_check
    $error("mmx_exec: ADDR_W must equal BANK_W + 8 and BANK_W must match the access bank width");
  end

  // decode the upper byte into one of the handled operations
  function automatic mmx_op_t decode_op(input logic [15:0] word);
    logic [7:0] opb;
    opb = word[MMX_OP_HI:MMX_OP_LO];
    if (opb == MMX_OP_LOAD_LIT) begin
      decode_op = MMX_LOAD_LIT;
    end else if (opb == MMX_OP_MUL_LIT) begin
      decode_op = MMX_MUL_LIT;
    end else if (opb[7:1] == MMX_OP_STORE_F) begin
      decode_op = MMX_STORE_F;
    end else if (opb[7:1] == MMX_OP_MUL_F) begin
      decode_op = MMX_MUL_F;
    end else begin
      decode_op = MMX_NONE;
    end
  endfunction : decode_op

  mmx_phase_t phase_ff, nxt_phase;
  mmx_op_t op_ff, nxt_op;
  logic [7:0] arg_ff, nxt_arg;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [7:0] operand_ff, nxt_operand;
  logic [15:0] product_ff, nxt_product;
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] prod_hi_ff, nxt_prod_hi;
  logic [7:0] prod_lo_ff, nxt_prod_lo;
  logic take_ff, nxt_take;
  logic mem_rd_ff, nxt_mem_rd;
  logic mem_wr_ff, nxt_mem_wr;
  logic [7:0] mem_wdata_ff, nxt_mem_wdata;
  logic done_ff, nxt_done;
  mmx_op_t dec_op;

  mmx_addr_if #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) addr_bus ();

  // address former sees the fields of the word being decoded
  assign addr_bus.access_bit = INSTR_WORD[MMX_ABIT_POS];
  assign addr_bus.file_field = INSTR_WORD[MMX_ARG_HI:MMX_ARG_LO];
  assign addr_bus.bank_select_reg = BANK_SEL;
  assign addr_bus.ext_set_en = EXT_SET_EN;
  assign addr_bus.index_base = INDEX_BASE;
  assign dec_op = decode_op(INSTR_WORD);

  mmx_addr_gen #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) u_addr_gen (
    .addr(addr_bus.former)
  );

  // phase sequencer and instruction capture
  always_comb begin
    nxt_phase = phase_ff;
    nxt_op = op_ff;
    nxt_arg = arg_ff;
    nxt_addr = addr_ff;
    nxt_take = 1'b0;
    case (phase_ff)
      MMX_PH_DECODE: begin
        nxt_phase = MMX_PH_READ;
        // an idle decode slot runs the phases as a no-operation
        nxt_op = INSTR_VALID ? dec_op : MMX_NONE;
        nxt_arg = INSTR_WORD[MMX_ARG_HI:MMX_ARG_LO];
        nxt_addr = addr_bus.full_addr;
      end
      MMX_PH_READ: begin
        nxt_phase = MMX_PH_PROCESS;
      end
      MMX_PH_PROCESS: begin
        nxt_phase = MMX_PH_WRITE;
      end
      MMX_PH_WRITE: begin
        // the next word is offered while the current one retires, so one word per instruction cycle
        nxt_phase = MMX_PH_DECODE;
        nxt_take = 1'b1;
      end
      default: begin
        nxt_phase = MMX_PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      phase_ff <= MMX_PH_DECODE;
      op_ff <= MMX_NONE;
      arg_ff <= 8'h00;
      addr_ff <= '0;
      take_ff <= 1'b1;
    end else begin
      phase_ff <= nxt_phase;
      op_ff <= nxt_op;
      arg_ff <= nxt_arg;
      addr_ff <= nxt_addr;
      take_ff <= nxt_take;
    end
  end

  // operand read, process and data memory strobes
  always_comb begin
    nxt_operand = operand_ff;
    nxt_product = product_ff;
    nxt_mem_rd = 1'b0;
    nxt_mem_wr = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    case (phase_ff)
      MMX_PH_DECODE: begin
        // only the file multiply needs the memory operand; the store needs no read
        nxt_mem_rd = INSTR_VALID && (dec_op == MMX_MUL_F);
      end
      MMX_PH_READ: begin
        nxt_operand = arg_ff;
      end
      MMX_PH_PROCESS: begin
        if (op_ff == MMX_MUL_F) begin
          nxt_product = 16'(acc_ff) * 16'(MEM_RDATA);
        end else begin
          nxt_product = 16'(acc_ff) * 16'(operand_ff);
        end
        nxt_mem_wr = (op_ff == MMX_STORE_F);
        nxt_mem_wdata = acc_ff;
      end
      MMX_PH_WRITE: begin
        nxt_mem_wdata = mem_wdata_ff;
      end
      default: begin
        nxt_mem_rd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      operand_ff <= 8'h00;
      product_ff <= 16'h0000;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_wdata_ff <= 8'h00;
    end else begin
      operand_ff <= nxt_operand;
      product_ff <= nxt_product;
      mem_rd_ff <= nxt_mem_rd;
      mem_wr_ff <= nxt_mem_wr;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  // write phase: accumulator and product pair; no status flag exists on this path
  always_comb begin
    nxt_acc = acc_ff;
    nxt_prod_hi = prod_hi_ff;
    nxt_prod_lo = prod_lo_ff;
    nxt_done = 1'b0;
    if (phase_ff == MMX_PH_WRITE) begin
      nxt_done = (op_ff != MMX_NONE);
      case (op_ff)
        MMX_LOAD_LIT: begin
          nxt_acc = arg_ff;
        end
        MMX_MUL_LIT, MMX_MUL_F: begin
          // a zero product is stored like any other, nothing is flagged
          nxt_prod_hi = product_ff[15:8];
          nxt_prod_lo = product_ff[7:0];
        end
        default: begin
          nxt_acc = acc_ff;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      acc_ff <= MMX_ACC_RST;
      prod_hi_ff <= MMX_PROD_RST;
      prod_lo_ff <= MMX_PROD_RST;
      done_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      prod_hi_ff <= nxt_prod_hi;
      prod_lo_ff <= nxt_prod_lo;
      done_ff <= nxt_done;
    end
  end

  // every output leaves straight from a flip-flop
  assign INSTR_TAKE = take_ff;
  assign MEM_ADDR = addr_ff;
  assign MEM_RD = mem_rd_ff;
  assign MEM_WR = mem_wr_ff;
  assign MEM_WDATA = mem_wdata_ff;
  assign ACC = acc_ff;
  assign PROD_HI = prod_hi_ff;
  assign PROD_LO = prod_lo_ff;
  assign DONE = done_ff;

endmodule : mmx_exec

/* File: tb/mmx_exec_sva.sv */
// mmx_exec_sva: port timing and value checks for the move and multiply datapath
// assumes the four-phase cycle free-runs from reset release
`timescale 1ns/1ps
module mmx_exec_sva
  import mmx_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int BANK_W = 4
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // instruction and addressing context
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic INSTR_TAKE,
  input wire logic [BANK_W-1:0] BANK_SEL,
  input wire logic EXT_SET_EN,
  input wire logic [ADDR_W-1:0] INDEX_BASE,
  // memory port and state
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic [7:0] ACC,
  input wire logic [7:0] PROD_HI,
  input wire logic [7:0] PROD_LO,
  input wire logic DONE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // decode of the word taken in this slot
  wire logic take = INSTR_TAKE && INSTR_VALID;
  wire logic [7:0] opc = INSTR_WORD[15:8];
  wire logic [7:0] fld = INSTR_WORD[7:0];
  wire logic st = take && opc[7:1] == MMX_OP_STORE_F;
  wire logic mf = take && opc[7:1] == MMX_OP_MUL_F;
  wire logic ml = take && opc == MMX_OP_MUL_LIT;
  wire logic ld = take && opc == MMX_OP_LOAD_LIT;
  wire logic fop = st || mf;
  wire logic idx = EXT_SET_EN && fld <= MMX_INDEX_LIMIT;

  chk_phase_cycle: assert property (INSTR_TAKE |=> !INSTR_TAKE [*3] ##1 INSTR_TAKE)
    else $error("take slot not every fourth cycle");
  chk_load_acc: assert property (ld |-> ##4 ACC == $past(fld, 4) && DONE)
    else $error("literal load result wrong");
  chk_mul_lit: assert property (ml |-> ##4 ACC == $past(ACC, 2) &&
    {PROD_HI, PROD_LO} == 16'($past(ACC, 2)) * 16'($past(fld, 4)))
    else $error("literal product wrong");
  chk_mul_file: assert property (mf |-> ##1 MEM_RD ##3
    {PROD_HI, PROD_LO} == 16'($past(ACC, 2)) * 16'($past(MEM_RDATA, 2)))
    else $error("file product wrong");
  chk_store_data: assert property (st |-> ##3 MEM_WR && MEM_WDATA == $past(ACC) ##1 DONE)
    else $error("store data wrong");
  chk_wr_cause: assert property (MEM_WR |-> $past(st, 3))
    else $error("write strobe without store");
  chk_bank_addr: assert property (fop && INSTR_WORD[8] |=> MEM_ADDR == {$past(BANK_SEL), $past(fld)})
    else $error("banked address wrong");
  chk_index_addr: assert property (fop && !INSTR_WORD[8] && idx |=> MEM_ADDR == $past(INDEX_BASE) + $past(fld))
    else $error("indexed address wrong");
  chk_access_addr: assert property (fop && !INSTR_WORD[8] && !idx |=>
    MEM_ADDR == {($past(fld) >= MMX_ACCESS_SPLIT) ? MMX_ACCESS_HIGH_BANK : MMX_ACCESS_LOW_BANK, $past(fld)})
    else $error("access bank address wrong");
  chk_done_cause: assert property (DONE |-> INSTR_TAKE && $past(take, 4))
    else $error("done without retired instruction");
endmodule : mmx_exec_sva

/* File: tb/mmx_mem_model.sv */
// mmx_mem_model: behavioural data memory on the far side of the memory port
// assumes read data is wanted only in the cycle after the read strobe
`timescale 1ns/1ps
module mmx_mem_model #(
  parameter int ADDR_W = 12
) (
  // clock
  input wire logic SYS_CLK,
  // memory port
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  initial MEM_RDATA = 8'h00;
  // outside the read slot the bus flips, so a late sample cannot pass by luck
  always @(posedge SYS_CLK) begin
    if (MEM_WR) begin
      mem[MEM_ADDR] <= MEM_WDATA;
    end
    MEM_RDATA <= MEM_RD ? mem[MEM_ADDR] : ~MEM_RDATA;
  end
endmodule : mmx_mem_model

/* File: tb/tb_top.sv */
// tb_top: directed checks of the move and multiply datapath with a memory model
// assumes a free-running four-phase cycle; one idle slot is left between instructions
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("FAIL %s exp %h got %h", n, e, g); \
  end \
end
module tb_top
  import mmx_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, valid = 1'b0, ext = 1'b0, take, rd, wr, done;
  logic [15:0] word = 16'h0000;
  logic [3:0] bank = 4'h0, cb = 4'h0;
  logic ce = 1'b0;
  // index base near the top of the data space so the indexed store wraps
  logic [11:0] base = 12'hFF0, addr;
  logic [7:0] rdata, wdata, acc, ph, pl;
  int miscompares = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  mmx_exec dut (.SYS_CLK(clk), .RSTN(rstn), .INSTR_VALID(valid), .INSTR_WORD(word), .INSTR_TAKE(take),
    .BANK_SEL(bank), .EXT_SET_EN(ext), .INDEX_BASE(base), .MEM_ADDR(addr), .MEM_RD(rd), .MEM_RDATA(rdata),
    .MEM_WR(wr), .MEM_WDATA(wdata), .ACC(acc), .PROD_HI(ph), .PROD_LO(pl), .DONE(done));
  mmx_mem_model mem_m (.SYS_CLK(clk), .MEM_ADDR(addr), .MEM_RD(rd), .MEM_WR(wr), .MEM_WDATA(wdata), .MEM_RDATA(rdata));
  // drive one word in a decode slot, return mid decode of the slot where it retired
  task automatic issue(input logic [15:0] w);
    repeat (4) @(posedge clk);
    valid <= 1'b1;
    word <= w;
    bank <= cb;
    ext <= ce;
    @(posedge clk);
    valid <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : issue
  task automatic t_load;
    logic [7:0] k [3] = '{8'h00, 8'hFF, 8'h5A};
    foreach (k[i]) begin
      issue({MMX_OP_LOAD_LIT, k[i]});
      `CHK("acc", k[i], acc)
      `CHK("done", 1'b1, done)
    end
  endtask : t_load
  task automatic t_mul_lit;
    logic [7:0] a [3] = '{8'hE2, 8'hFF, 8'h00};
    logic [7:0] b [3] = '{8'hC4, 8'hFF, 8'h37};
    foreach (a[i]) begin
      issue({MMX_OP_LOAD_LIT, a[i]});
      issue({MMX_OP_MUL_LIT, b[i]});
      `CHK("prod", 16'(a[i]) * 16'(b[i]), {ph, pl})
      `CHK("acc", a[i], acc)
    end
  endtask : t_mul_lit
  // every addressing path, including both sides of the indexed limit
  task automatic t_store;
    logic [3:0] bk [6] = '{4'h5, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3};
    logic ex [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [8:0] af [6] = '{9'h1FF, 9'h010, 9'h060, 9'h05F, 9'h060, 9'h120};
    logic [11:0] ea [6] = '{12'h5FF, 12'h010, 12'hF60, 12'h04F, 12'hF60, 12'h320};
    foreach (bk[i]) begin
      cb = bk[i];
      ce = ex[i];
      issue({MMX_OP_LOAD_LIT, 8'(i) + 8'h41});
      issue({MMX_OP_STORE_F, af[i]});
      `CHK("mem", 8'(i) + 8'h41, mem_m.mem[ea[i]])
    end
    ce = 1'b0;
  endtask : t_store
  task automatic t_mul_file;
    logic [8:0] af [2] = '{9'h135, 9'h0F0};
    logic [11:0] ea [2] = '{12'h235, 12'hFF0};
    cb = 4'h2;
    foreach (af[i]) begin
      mem_m.mem[ea[i]] = 8'hB5 - 8'(i);
      issue({MMX_OP_LOAD_LIT, 8'hC4});
      issue({MMX_OP_MUL_F, af[i]});
      `CHK("prod", 16'(8'hC4) * 16'(8'hB5 - 8'(i)), {ph, pl})
      `CHK("acc", 8'hC4, acc)
      `CHK("mem", 8'hB5 - 8'(i), mem_m.mem[ea[i]])
    end
  endtask : t_mul_file
  // a word of no handled pattern must leave the state alone
  task automatic t_refuse;
    issue(16'hFFFF);
    `CHK("acc", 8'hC4, acc)
    `CHK("prod", 16'(8'hC4) * 16'(8'hB4), {ph, pl})
    `CHK("done", 1'b0, done)
  endtask : t_refuse
  // a reset in mid-run restarts the phases in decode with the state cleared
  task automatic t_reset;
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    `CHK("take", 1'b1, take)
    `CHK("acc", MMX_ACC_RST, acc)
    `CHK("prod", {MMX_PROD_RST, MMX_PROD_RST}, {ph, pl})
    issue({MMX_OP_LOAD_LIT, 8'h3C});
    `CHK("acc", 8'h3C, acc)
  endtask : t_reset
  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // reset, find a decode slot, then the scenarios
  initial begin
    int n;
    n = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(negedge clk);
    while (take === 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    while (take !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    t_load();
    t_mul_lit();
    t_store();
    t_mul_file();
    t_refuse();
    t_reset();
    tally_and_finish();
  end
endmodule : tb_top
bind mmx_exec mmx_exec_sva #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD), .INSTR_TAKE(INSTR_TAKE), .BANK_SEL(BANK_SEL),
  .EXT_SET_EN(EXT_SET_EN), .INDEX_BASE(INDEX_BASE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA),
  .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .ACC(ACC), .PROD_HI(PROD_HI), .PROD_LO(PROD_LO), .DONE(DONE));
